// file: src/flash_host_pkg.sv
/*
  constants, register map and state type of the parallel flash host.
  assumes a 10 MHz clock and an AHB-Lite master with 32-bit data.
*/
// Summary of operation
// - host loads a byte by pulsing write strobe low, output enable high
// - sectors hold 128 bytes; unloaded bytes end up erased to ff
// - next load starts within 150 us, otherwise programming begins
// - host keeps one sector address for every load of a sector
// - with the write guard on, three guard writes precede every sector
`default_nettype none
package flash_host_pkg;
    localparam int ADDR_W        = 17;
    localparam int DATA_W        = 8;
    localparam int SECTOR_LSB    = 7;
    localparam int BOOT_LSB      = 13;
    localparam logic [3:0] BOOT_LO = 4'h0;
    localparam logic [3:0] BOOT_HI = 4'hf;
    localparam logic [1:0] GUARD_LEN = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int WIN_US        = 150;
    localparam int WIN_CYC       = (WIN_US * 1000) / CLK_PERIOD_NS;
    localparam int WIN_LEAD_CYC  = 4;
    localparam int WIN_USE_CYC   = WIN_CYC - WIN_LEAD_CYC;
    localparam int NOISE_NS      = 15;
    localparam int PULSE_CYC     = (NOISE_NS + CLK_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int ACC_NS        = 70;
    localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES   = 2;
    localparam int PWRUP_MS      = 5;
    localparam int PWRUP_CYC     = (PWRUP_MS * 1000000) / CLK_PERIOD_NS;
    localparam int PROG_MS       = 10;
    localparam int PROG_CYC      = (PROG_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TMR_W         = 17;
    localparam int WAIT_W        = 3;
    // register byte offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_ADDR   = 8'h04;
    localparam logic [7:0] OFS_WDATA  = 8'h08;
    localparam logic [7:0] OFS_RDATA  = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CFG    = 8'h14;
    // command codes in bits 1:0 of the command register
    localparam logic [1:0] OP_READ   = 2'h0;
    localparam logic [1:0] OP_LOAD   = 2'h1;
    localparam logic [1:0] OP_PREFIX = 2'h2;
    // configuration bits
    localparam int CFG_GUARD   = 0;
    localparam int CFG_LOCK_LO = 1;
    localparam int CFG_LOCK_HI = 2;
    // status bits
    localparam int ST_BUSY    = 0;
    localparam int ST_WIN     = 1;
    localparam int ST_POLL    = 2;
    localparam int ST_PWR     = 3;
    localparam int ST_ERR_REF = 4;
    localparam int ST_ERR_TMO = 5;
    localparam int ST_FULL    = 6;
    localparam int ST_DONE    = 7;
    localparam int ST_CNT_LSB = 8;
    localparam int ST_PFX_LSB = 16;

    typedef enum logic [2:0] {
        S_IDLE, S_RD_ACC, S_LD_SET, S_LD_LOW, S_LD_HOLD, S_PL_ACC, S_PL_GAP
    } host_state_e;
endpackage
`default_nettype wire

// file: src/pin_sync.sv
/*
  two-flop synchroniser for a bus of pin inputs.
  assumes inputs are asynchronous to clk; bits are not coherent as a word.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_in,
    output var  logic [W-1:0] pin_out
);
    // one pair of flops per bit; the first is read by the second only
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic meta_r;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_r     <= 1'b0;
                pin_out[i] <= 1'b0;
            end else begin
                meta_r     <= pin_in[i];
                pin_out[i] <= meta_r;
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// file: src/cycle_timer.sv
/*
  loadable down counter giving a one-cycle pulse when the count runs out.
  assumes start and stop come from logic on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module cycle_timer #(
    parameter int W = 17
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] len,
    output logic              running,
    output logic              done
);
    logic [W-1:0] cnt_r;

    // start wins over stop; count down to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= len;
        end else if (stop) begin
            cnt_r <= '0;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // done marks the last counted cycle
    assign running = (cnt_r != '0);
    assign done    = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !start && !stop;
endmodule // cycle_timer
`default_nettype wire

// file: src/flash_host.sv
/*
  host controller for a 128K x 8 sector-programmed parallel flash.
  software drives it through AHB-Lite registers; it runs reads, byte
  loads, the sector load window and completion polling on the pins.
  assumes the flash pins are joined by the bench; data_lines_in is async.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_host #(
    parameter int PWRUP_CYCLES = flash_host_pkg::PWRUP_CYC,
    parameter int PROG_CYCLES  = flash_host_pkg::PROG_CYC
) (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              hsel,
    input  wire logic [31:0]                       haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [31:0]                       hwdata,
    input  wire logic                              hready,
    output logic                                   hreadyout,
    output logic                                   hresp,
    output logic [31:0]                            hrdata,
    output logic [flash_host_pkg::ADDR_W-1:0]      address_lines,
    output logic [flash_host_pkg::DATA_W-1:0]      data_lines_out,
    output logic                                   data_lines_oe,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_lines_in,
    output logic                                   chip_sel_n,
    output logic                                   out_en_n,
    output logic                                   write_strobe_n
);
    import flash_host_pkg::*;

    if (PWRUP_CYCLES < 1 || PWRUP_CYCLES >= (1 << TMR_W) ||
        PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TMR_W)) begin : g_bad
        $error("timer parameter out of range");
    end

    host_state_e          state_r, state_nxt;
    logic [WAIT_W-1:0]    wait_r;
    logic                 ap_valid_r, ap_write_r;
    logic [7:0]           ap_addr_r;
    logic                 wr_cmd, wr_addr, wr_data, wr_cfg, wr_stat;
    logic [ADDR_W-1:0]    addr_r, last_addr_r;
    logic [DATA_W-1:0]    wdata_r, last_data_r, rdata_r, din_sync;
    logic [9:0]           sector_r;
    logic [127:0]         loaded_r;
    logic [7:0]           load_cnt_r;
    logic [1:0]           prefix_cnt_r;
    logic                 guard_r, lock_lo_r, lock_hi_r;
    logic                 go_read, go_load, go_prefix, refuse, take;
    logic                 boot_locked, start_poll, poll_ok;
    logic                 polling_r, have_prev_r, prev6_r, done_r;
    logic                 err_ref_r, err_tmo_r, pwr_ok_r, pwr_started_r;
    logic                 win_open, win_done, prog_done, pwr_done;
    logic [31:0]          status_w;

    // asynchronous data pins pass two flops first
    pin_sync #(.W(DATA_W)) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pin_in  (data_lines_in),
        .pin_out (din_sync)
    );

    // power-up hold-off, started once after reset release
    cycle_timer #(.W(TMR_W)) u_pwr (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (!pwr_started_r),
        .stop    (1'b0),
        .len     (TMR_W'(PWRUP_CYCLES)),
        .running (),
        .done    (pwr_done)
    );

    // sector load window, restarted at each strobe rise
    cycle_timer #(.W(TMR_W)) u_win (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (state_r == S_LD_LOW && state_nxt == S_LD_HOLD),
        .stop    (go_load || go_prefix),
        .len     (TMR_W'(WIN_USE_CYC)),
        .running (win_open),
        .done    (win_done)
    );

    // limit on the program cycle while polling
    cycle_timer #(.W(TMR_W)) u_prog (
        .clk     (clk),
        .rst_n   (rst_n),
        .start   (start_poll),
        .stop    (take && state_r == S_PL_ACC && poll_ok),
        .len     (TMR_W'(PROG_CYCLES)),
        .running (),
        .done    (prog_done)
    );

    // bus address phase; the slave never inserts wait states
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ap_valid_r <= 1'b0;
            ap_write_r <= 1'b0;
            ap_addr_r  <= 8'h00;
        end else if (hready) begin
            ap_valid_r <= hsel && htrans[1];
            ap_write_r <= hwrite;
            ap_addr_r  <= haddr[7:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // write decode in the data phase; unmapped writes are dropped
    always_comb begin
        wr_cmd  = 1'b0;
        wr_addr = 1'b0;
        wr_data = 1'b0;
        wr_cfg  = 1'b0;
        wr_stat = 1'b0;
        if (ap_valid_r && ap_write_r) begin
            if (ap_addr_r == OFS_CMD) wr_cmd = 1'b1;
            else if (ap_addr_r == OFS_ADDR) wr_addr = 1'b1;
            else if (ap_addr_r == OFS_WDATA) wr_data = 1'b1;
            else if (ap_addr_r == OFS_CFG) wr_cfg = 1'b1;
            else if (ap_addr_r == OFS_STATUS) wr_stat = 1'b1;
        end
    end

    // status word
    assign status_w = {14'h0000, prefix_cnt_r, load_cnt_r, done_r,
                       &loaded_r, err_tmo_r, err_ref_r, pwr_ok_r,
                       polling_r, win_open,
                       (state_r != S_IDLE) || polling_r};

    // read data registered in the address phase; unmapped reads give zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            if (haddr[7:0] == OFS_ADDR) hrdata <= {15'h0000, addr_r};
            else if (haddr[7:0] == OFS_WDATA) hrdata <= {24'h000000, wdata_r};
            else if (haddr[7:0] == OFS_RDATA) hrdata <= {24'h000000, rdata_r};
            else if (haddr[7:0] == OFS_STATUS) hrdata <= status_w;
            else if (haddr[7:0] == OFS_CFG)
                hrdata <= {29'h0000_0000, lock_hi_r, lock_lo_r, guard_r};
            else hrdata <= 32'h0000_0000;
        end
    end

    // software-written registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r    <= '0;
            wdata_r   <= '0;
            guard_r   <= 1'b0;
            lock_lo_r <= 1'b0;
            lock_hi_r <= 1'b0;
        end else begin
            if (wr_addr) addr_r <= hwdata[ADDR_W-1:0];
            if (wr_data) wdata_r <= hwdata[DATA_W-1:0];
            if (wr_cfg) begin
                guard_r   <= hwdata[CFG_GUARD];
                lock_lo_r <= hwdata[CFG_LOCK_LO];
                lock_hi_r <= hwdata[CFG_LOCK_HI];
            end
        end
    end

    // boot blocks are the lowest and highest 8K bytes
    assign boot_locked =
        (lock_lo_r && addr_r[ADDR_W-1:BOOT_LSB] == BOOT_LO) ||
        (lock_hi_r && addr_r[ADDR_W-1:BOOT_LSB] == BOOT_HI);

    // command acceptance; anything not served is refused
    always_comb begin
        go_read   = 1'b0;
        go_load   = 1'b0;
        go_prefix = 1'b0;
        refuse    = 1'b0;
        if (wr_cmd) begin
            if (state_r != S_IDLE || polling_r || !pwr_ok_r || win_done) begin
                refuse = 1'b1;
            end else if (hwdata[1:0] == OP_READ && !win_open) begin
                go_read = 1'b1;
            end else if (hwdata[1:0] == OP_LOAD) begin
                if (guard_r && prefix_cnt_r != GUARD_LEN) refuse = 1'b1;
                else if (load_cnt_r != 8'h00 &&
                         addr_r[ADDR_W-1:SECTOR_LSB] != sector_r)
                    refuse = 1'b1;
                else if (boot_locked) refuse = 1'b1;
                else go_load = 1'b1;
            end else if (hwdata[1:0] == OP_PREFIX && load_cnt_r == 8'h00 &&
                         prefix_cnt_r != GUARD_LEN) begin
                go_prefix = 1'b1;
            end else begin
                refuse = 1'b1;
            end
        end
    end

    // window end with bytes loaded starts polling
    assign start_poll = win_done && load_cnt_r != 8'h00;
    // done when bit 7 is true and bit 6 stopped toggling
    assign poll_ok = have_prev_r && din_sync[7] == last_data_r[7] &&
                     din_sync[6] == prev6_r;

    // pin sequencer
    always_comb begin
        state_nxt = state_r;
        take      = 1'b0;
        case (state_r)
            S_IDLE: begin
                if (go_read) state_nxt = S_RD_ACC;
                else if (go_load || go_prefix) state_nxt = S_LD_SET;
                else if (start_poll) state_nxt = S_PL_GAP;
            end
            S_RD_ACC: begin
                if (wait_r == '0) begin
                    take      = 1'b1;
                    state_nxt = S_IDLE;
                end
            end
            S_LD_SET: state_nxt = S_LD_LOW;
            S_LD_LOW: if (wait_r == '0) state_nxt = S_LD_HOLD;
            S_LD_HOLD: state_nxt = S_IDLE;
            S_PL_ACC: begin
                if (prog_done) begin
                    state_nxt = S_IDLE;
                end else if (wait_r == '0) begin
                    take      = 1'b1;
                    state_nxt = poll_ok ? S_IDLE : S_PL_GAP;
                end
            end
            // first gap also waits out the flash's own load window
            S_PL_GAP: begin
                if (prog_done) state_nxt = S_IDLE;
                else if (wait_r == '0) state_nxt = S_PL_ACC;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // state and wait counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            wait_r  <= '0;
        end else begin
            state_r <= state_nxt;
            if ((state_nxt == S_RD_ACC || state_nxt == S_PL_ACC) &&
                state_r != state_nxt)
                wait_r <= WAIT_W'(ACC_CYC + SYNC_STAGES - 1);
            else if (state_nxt == S_PL_GAP && state_r == S_IDLE)
                wait_r <= WAIT_W'(WIN_LEAD_CYC + SYNC_STAGES);
            else if (state_nxt == S_LD_LOW && state_r != S_LD_LOW)
                wait_r <= WAIT_W'(PULSE_CYC - 1);
            else if (wait_r != '0)
                wait_r <= wait_r - 1'b1;
        end
    end

    // registered pin controls; strobe never low with output enable low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_sel_n     <= 1'b1;
            out_en_n       <= 1'b1;
            write_strobe_n <= 1'b1;
            data_lines_oe  <= 1'b0;
        end else begin
            chip_sel_n     <= !(state_nxt inside {S_RD_ACC, S_PL_ACC,
                               S_LD_SET, S_LD_LOW, S_LD_HOLD});
            out_en_n       <= !(state_nxt inside {S_RD_ACC, S_PL_ACC});
            write_strobe_n <= !(state_nxt == S_LD_LOW);
            data_lines_oe  <= state_nxt inside {S_LD_SET, S_LD_LOW,
                                                S_LD_HOLD};
        end
    end

    // address and data stay put from select fall to select rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            address_lines  <= '0;
            data_lines_out <= '0;
        end else if (state_r == S_IDLE) begin
            if (start_poll && !go_read) address_lines <= last_addr_r;
            else if (go_read || go_load || go_prefix) address_lines <= addr_r;
            if (go_load || go_prefix) data_lines_out <= wdata_r;
        end
    end

    // sector bookkeeping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sector_r     <= '0;
            loaded_r     <= '0;
            load_cnt_r   <= 8'h00;
            prefix_cnt_r <= 2'h0;
            last_addr_r  <= '0;
            last_data_r  <= '0;
        end else if (win_done) begin
            load_cnt_r   <= 8'h00;
            prefix_cnt_r <= 2'h0;
        end else if (go_prefix) begin
            prefix_cnt_r <= prefix_cnt_r + 2'h1;
        end else if (go_load) begin
            last_addr_r <= addr_r;
            last_data_r <= wdata_r;
            if (load_cnt_r == 8'h00) begin
                sector_r   <= addr_r[ADDR_W-1:SECTOR_LSB];
                loaded_r   <= 128'h1 << addr_r[SECTOR_LSB-1:0];
                load_cnt_r <= 8'h01;
            end else if (!loaded_r[addr_r[SECTOR_LSB-1:0]]) begin
                loaded_r[addr_r[SECTOR_LSB-1:0]] <= 1'b1;
                load_cnt_r <= load_cnt_r + 8'h01;
            end
        end
    end

    // polling state and read capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            polling_r   <= 1'b0;
            have_prev_r <= 1'b0;
            prev6_r     <= 1'b0;
            done_r      <= 1'b0;
            rdata_r     <= '0;
        end else if (start_poll) begin
            polling_r   <= 1'b1;
            have_prev_r <= 1'b0;
            done_r      <= 1'b0;
        end else if (polling_r && (prog_done ||
                     (state_r == S_PL_ACC && take && poll_ok))) begin
            polling_r <= 1'b0;
            done_r    <= !prog_done;
            rdata_r   <= din_sync;
        end else if (take) begin
            if (state_r == S_PL_ACC) begin
                have_prev_r <= 1'b1;
                prev6_r     <= din_sync[6];
            end
            rdata_r <= din_sync;
        end else if (go_load) begin
            done_r <= 1'b0;
        end
    end

    // error flags and power gate; a set wins over a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_ref_r     <= 1'b0;
            err_tmo_r     <= 1'b0;
            pwr_ok_r      <= 1'b0;
            pwr_started_r <= 1'b0;
        end else begin
            pwr_started_r <= 1'b1;
            if (pwr_done) pwr_ok_r <= 1'b1;
            err_ref_r <= refuse | (err_ref_r & ~(wr_stat & hwdata[ST_ERR_REF]));
            err_tmo_r <= (prog_done & polling_r) |
                         (err_tmo_r & ~(wr_stat & hwdata[ST_ERR_TMO]));
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    strobe_oe_excl_a: assert property (!write_strobe_n |-> out_en_n)
        else $error("strobe low with output enable low");
    load_select_a: assert property (!write_strobe_n |-> !chip_sel_n)
        else $error("strobe low without chip select");
    drive_oe_high_a: assert property (data_lines_oe |-> out_en_n)
        else $error("host drives data while flash may drive");
    addr_at_fall_a: assert property ($fell(write_strobe_n) |->
        $stable(address_lines) && $past(!chip_sel_n))
        else $error("address not settled before strobe fall");
    data_at_rise_a: assert property ($rose(write_strobe_n) |->
        !chip_sel_n && data_lines_oe && $stable(data_lines_out))
        else $error("data not held at strobe rise");
    pulse_width_a: assert property ($fell(write_strobe_n) |=> $rose(write_strobe_n))
        else $error("strobe pulse width wrong");
    same_sector_a: assert property ($fell(write_strobe_n) && load_cnt_r != 8'h00
        && $past(go_load, 2) |-> address_lines[ADDR_W-1:SECTOR_LSB] == sector_r)
        else $error("sector changed within load window");
    poll_start_a: assert property (start_poll |=>
        polling_r && out_en_n ##7 !out_en_n)
        else $error("polling did not follow window close");
    poll_addr_a: assert property (polling_r && !out_en_n |->
        address_lines == last_addr_r)
        else $error("polling read at wrong address");
    pwr_block_a: assert property (!pwr_ok_r |-> write_strobe_n)
        else $error("load before power-up delay");
    guard_order_a: assert property (go_load && guard_r |->
        prefix_cnt_r == GUARD_LEN)
        else $error("guarded load without guard writes");
endmodule // flash_host
`default_nettype wire

// file: testbench/flash_model.sv
/* flash device model: array, byte loads, load window, polling.
   assumes the host's pins on one wire each; times in ns. */
`timescale 1ns/1ns
`default_nettype none
module flash_model #(
    parameter int PROG_NS = 5000,
    parameter int PWR_NS  = 1000
) (
    input  wire logic [16:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic [7:0]  din,
    output logic [7:0]       dq
);
    logic [7:0]   mem [0:131071];
    logic [7:0]   pg [0:127];
    logic [7:0]   lb, v, last;
    logic [127:0] ld;
    logic [16:0]  la;
    logic         open, busy, tog, pwr;
    realtime      tf, tl;
    wire st = ce_n | we_n;
    wire rd = !ce_n && !oe_n && we_n;
    // array preset, programming blocked until supply settles
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = i[7:0];
        {ld, open, busy, tog, pwr, last} = '0;
        #PWR_NS pwr = 1'b1;
    end
    // released lines show the inverse of the last value
    assign v = busy ? {~lb[7], tog, lb[5:0]} : mem[addr];
    assign dq = rd ? v : ~last;
    always @(negedge rd) last = v;
    always @(posedge rd) if (busy) tog = ~tog;
    // address on the later fall, data on the first rise
    always @(negedge st) if (oe_n) begin
        tf = $realtime;
        la = addr;
    end
    always @(posedge st) if (oe_n && pwr && $realtime - tf >= 15) begin
        pg[la[6:0]] = din;
        ld[la[6:0]] = 1'b1;
        lb = din;
        tl = $realtime;
        open = 1'b1;
    end
    // window close, sector erase, then program
    always #100 if (open && $realtime - tl >= 150000) begin
        open = 1'b0;
        busy = 1'b1;
        #PROG_NS;
        for (int i = 0; i < 128; i++)
            mem[{la[16:7], i[6:0]}] = ld[i] ? pg[i] : 8'hff;
        ld = '0;
        busy = 1'b0;
    end
endmodule // flash_model
`default_nettype wire

// file: testbench/sector_flash_program_control_tb.sv
/* self-checking bench for flash_host with the flash model.
   assumes 10 MHz clock and a zero-wait AHB-Lite slave. */
`timescale 1ns/1ns
`default_nettype none
module sector_flash_program_control_tb;
    import flash_host_pkg::*;
    logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
    logic        dq_oe, ce_n, oe_n, we_n;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [16:0] addr;
    logic [7:0]  dq_out, dq_fl;
    int          errors, tests_run;
    wire logic [7:0] dq_in = dq_oe ? dq_out : dq_fl;
    flash_host #(.PWRUP_CYCLES(20), .PROG_CYCLES(200)) uut (.clk(clk),
        .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .address_lines(addr), .data_lines_out(dq_out),
        .data_lines_oe(dq_oe), .data_lines_in(dq_in), .chip_sel_n(ce_n),
        .out_en_n(oe_n), .write_strobe_n(we_n));
    flash_model fl (.addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .din(dq_out), .dq(dq_fl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one single transfer; read data lands in r
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic op(input logic [16:0] a, input logic [7:0] d, c);
        bus(1'b1, OFS_ADDR, 32'(a));
        bus(1'b1, OFS_WDATA, 32'(d));
        bus(1'b1, OFS_CMD, 32'(c));
    endtask
    task automatic wait_st(input int b, input logic val);
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 0);
            n++;
        end while (r[b] !== val && n < 3000);
        if (r[b] !== val) errors++;
    endtask
    task automatic rd_byte(input logic [16:0] a, input logic [7:0] e);
        op(a, 8'h00, 8'(OP_READ));
        wait_st(ST_BUSY, 1'b0);
        bus(1'b0, OFS_RDATA, 0);
        chk({24'h0, r[7:0]}, 32'(e));
    endtask
    task automatic test_power;
        op(17'h00205, 8'ha5, 8'(OP_LOAD));
        bus(1'b0, OFS_STATUS, 0);
        chk(32'(r[ST_ERR_REF]), 1);
        repeat (30) @(posedge clk);
        bus(1'b1, OFS_STATUS, 32'h30);
        bus(1'b0, OFS_STATUS, 0);
        chk(32'(r[ST_PWR +: 2]), 1);
    endtask
    task automatic test_program;
        op(17'h00205, 8'ha5, 8'(OP_LOAD));
        op(17'h0027f, 8'hc3, 8'(OP_LOAD));
        op(17'h0027f, 8'hc3, 8'(OP_LOAD));
        bus(1'b0, OFS_STATUS, 0);
        chk(32'(r[ST_CNT_LSB +: 8]), 2);
        wait_st(ST_DONE, 1'b1);
        chk(32'(r[ST_ERR_TMO +: 3]), 4);
        rd_byte(17'h00205, 8'ha5);
        rd_byte(17'h0027f, 8'hc3);
    endtask
    task automatic test_lock;
        for (int i = 1; i < 3; i++) begin
            bus(1'b1, OFS_CFG, 32'(1 << i));
            op(i == 1 ? 17'h00010 : 17'h1ff10, 8'h11, 8'(OP_LOAD));
            bus(1'b0, OFS_STATUS, 0);
            chk(32'(r[ST_ERR_REF]), 1);
            bus(1'b1, OFS_STATUS, 32'h10);
        end
        rd_byte(17'h1ff10, 8'h10);
        bus(1'b0, 32'h40, 0);
        chk(r, 0);
    endtask
    // guard mode: a bare load is refused, three guard writes open it
    task automatic test_guard;
        bus(1'b1, OFS_CFG, 32'h1);
        op(17'h00405, 8'h5a, 8'(OP_LOAD));
        bus(1'b0, OFS_STATUS, 0);
        chk(32'(r[ST_ERR_REF]), 1);
        bus(1'b1, OFS_STATUS, 32'h10);
        repeat (3) op(17'h00405, 8'h5a, 8'(OP_PREFIX));
        op(17'h00405, 8'h5a, 8'(OP_LOAD));
        bus(1'b0, OFS_STATUS, 0);
        chk(32'(r[ST_CNT_LSB +: 10]), 32'h301);
        wait_st(ST_DONE, 1'b1);
        rd_byte(17'h00405, 8'h5a);
    endtask
    task automatic print_verdict;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // watchdog well beyond the expected few thousand cycles
    initial begin
        #5000000;
        errors++;
        print_verdict;
    end
    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        test_power;
        rd_byte(17'h001ab, 8'hab);
        test_program;
        test_lock;
        test_guard;
        print_verdict;
    end
endmodule // sector_flash_program_control_tb
`default_nettype wire
